// [logic/lpm_ctrl.sv]
// How it works
// R1: In sleep only the core clock stops; peripherals keep clocks and run.
// R2: Sleep ends on any pending interrupt or any event.
// R3: Deep-sleep stops core-domain clocks and turns off fast RC, crystal and PLL.
// R4: Deep-sleep keeps core-domain power, so memory and registers hold.
// R5: Deep-sleep ends on any event line, RTC alarm, supply drop, USB or ethernet wake.
// R6: Leaving deep-sleep always selects the fast RC as system clock.
// R7: Standby removes core-domain power, stops the regulator and the fast clocks.
// R8: Standby loses core-domain state; only the backup domain stays powered.
// R9: Standby ends only on reset pin, RTC, watchdog reset or wakeup pin rise.
// R10: A supply drop below threshold raises an interrupt pulse as a warning.
// R11: Standby wake restarts the core domain through a full reset hold.
`timescale 1ns/1ns
`default_nettype none

module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int unsigned CNT_W     = CNT_W_DEF,
    parameter int unsigned RC_SETTLE = RC_SETTLE_CYC,
    parameter int unsigned RST_HOLD  = RST_HOLD_CYC
)
(
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    input  wire logic       enter_req_in,
    input  wire lpm_mode_t  mode_sel_in,
    input  wire logic       irq_pending_in,
    input  wire lpm_wake_t  wake_in,
    input  wire logic       xtal_req_in,
    input  wire logic       pll_req_in,
    input  wire logic       supply_drop_in,
    input  wire logic       wakeup_pin_in,
    input  wire logic       ext_reset_pin_n_in,
    input  wire logic       wdg_reset_in,
    output lpm_ctrl_t       ctrl_out,
    output lpm_state_t      state_out,
    output logic            rc_sel_out,
    output logic            supply_drop_irq_out
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // Counter must hold both waits and neither wait may be zero
    if (RC_SETTLE < 1 || RC_SETTLE >= (1 << CNT_W))
        $error("lpm_ctrl: RC_SETTLE out of range");
    if (RST_HOLD < 1 || RST_HOLD >= (1 << CNT_W))
        $error("lpm_ctrl: RST_HOLD out of range");

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // One counter serves both waits; they never run at the same time
    localparam logic [CNT_W-1:0] RC_LOAD  = CNT_W'(RC_SETTLE - 1);
    localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RST_HOLD - 1);

    lpm_state_t       state_ff;
    lpm_state_t       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    lpm_ctrl_t        ctrl_ff;
    lpm_ctrl_t        nxt_ctrl;
    logic             rc_sel_ff;
    logic             nxt_rc_sel;
    logic             drop_irq_ff;
    logic             nxt_drop_irq;
    logic             pin_rise;
    logic             drop_rise;
    logic             any_event;
    logic             sleep_wake;
    logic             deep_wake;
    logic             stby_wake;

    // ------------------------------------------------------------------
    // Edge finders for wakeup pin and supply drop
    // ------------------------------------------------------------------
    lpm_rise_det #(
        .W        (1)
    ) u_pin_rise (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .level_in (wakeup_pin_in),
        .rise_out (pin_rise)
    );

    lpm_rise_det #(
        .W        (1)
    ) u_drop_rise (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .level_in (supply_drop_in),
        .rise_out (drop_rise)
    );

    // ------------------------------------------------------------------
    // Wake conditions
    // ------------------------------------------------------------------
    // Event lines include the supply drop warning
    assign any_event  = (|wake_in.ext_lines) | wake_in.rtc_alarm
                      | wake_in.usb_wake | wake_in.ethernet_unit_wake
                      | drop_rise;                             // [R5]
    assign sleep_wake = irq_pending_in | any_event;           // [R2]
    // Interrupts reach deep-sleep only through the event lines
    assign deep_wake  = any_event;                            // [R5]
    // Exactly four standby sources; nothing else is looked at
    assign stby_wake  = ~ext_reset_pin_n_in | wake_in.rtc_alarm
                      | wdg_reset_in | pin_rise;              // [R9]

    // ------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            LPM_ST_RUN:
            begin
                if (enter_req_in)
                begin
                    unique case (mode_sel_in)
                        LPM_MODE_SLEEP: nxt_state = LPM_ST_SLEEP;
                        LPM_MODE_DEEP:  nxt_state = LPM_ST_DEEP;
                        LPM_MODE_STBY:  nxt_state = LPM_ST_STBY;
                        default:        nxt_state = LPM_ST_RUN;
                    endcase
                end
            end
            LPM_ST_SLEEP:
            begin
                if (sleep_wake)
                    nxt_state = LPM_ST_RUN;                   // [R2]
            end
            LPM_ST_DEEP:
            begin
                if (deep_wake)
                begin
                    nxt_state = LPM_ST_DEEP_WAKE;             // [R5]
                    nxt_cnt   = RC_LOAD;
                end
            end
            LPM_ST_DEEP_WAKE:
            begin
                // Clocks return only once the fast RC has settled
                if (cnt_ff == '0)
                    nxt_state = LPM_ST_RUN;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            LPM_ST_STBY:
            begin
                if (stby_wake)
                begin
                    nxt_state = LPM_ST_STBY_WAKE;             // [R9]
                    nxt_cnt   = RST_LOAD;
                end
            end
            LPM_ST_STBY_WAKE:
            begin
                // Reset pin still low keeps the hold restarting
                if (!ext_reset_pin_n_in)
                    nxt_cnt = RST_LOAD;                       // [R11]
                else if (cnt_ff == '0)
                    nxt_state = LPM_ST_RUN;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            default:
            begin
                nxt_state = LPM_ST_RUN;
                nxt_cnt   = '0;
            end
        endcase
    end

    // State and count move together on one edge
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            state_ff <= LPM_ST_RUN;
            cnt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Clock and power controls, from the next state
    // ------------------------------------------------------------------
    // Outputs follow the next state so they change with the state itself
    always_comb
    begin
        nxt_ctrl              = CTRL_RESET;
        nxt_ctrl.fast_xtal_en = xtal_req_in;
        nxt_ctrl.pll_en       = pll_req_in;
        unique case (nxt_state)
            LPM_ST_RUN:
            begin
                nxt_ctrl.core_clk_en = 1'b1;
            end
            LPM_ST_SLEEP:
            begin
                // Peripherals and oscillators stay as they were
                nxt_ctrl.core_clk_en = 1'b0;                  // [R1]
            end
            LPM_ST_DEEP, LPM_ST_DEEP_WAKE:
            begin
                nxt_ctrl.core_clk_en   = 1'b0;                // [R3]
                nxt_ctrl.periph_clk_en = 1'b0;                // [R3]
                nxt_ctrl.dom_clk_en    = 1'b0;                // [R3]
                nxt_ctrl.fast_xtal_en  = 1'b0;                // [R3]
                nxt_ctrl.pll_en        = 1'b0;                // [R3]
                // RC restarts only during the wake wait
                nxt_ctrl.fast_rc_en    = (nxt_state == LPM_ST_DEEP_WAKE);
                // Power stays up, so memory and registers hold
                nxt_ctrl.dom_pwr_en    = 1'b1;                // [R4]
                nxt_ctrl.regulator_en  = 1'b1;                // [R4]
                nxt_ctrl.dom_rst       = 1'b0;                // [R4]
            end
            LPM_ST_STBY:
            begin
                nxt_ctrl.core_clk_en   = 1'b0;                // [R7]
                nxt_ctrl.periph_clk_en = 1'b0;                // [R7]
                nxt_ctrl.dom_clk_en    = 1'b0;                // [R7]
                nxt_ctrl.fast_rc_en    = 1'b0;                // [R7]
                nxt_ctrl.fast_xtal_en  = 1'b0;                // [R7]
                nxt_ctrl.pll_en        = 1'b0;                // [R7]
                nxt_ctrl.regulator_en  = 1'b0;                // [R7]
                nxt_ctrl.dom_pwr_en    = 1'b0;                // [R7]
                // State is gone; reset keeps the domain quiet
                nxt_ctrl.dom_rst       = 1'b1;                // [R8]
            end
            LPM_ST_STBY_WAKE:
            begin
                // Power and RC come back under reset
                nxt_ctrl.core_clk_en   = 1'b0;
                nxt_ctrl.periph_clk_en = 1'b0;
                nxt_ctrl.dom_clk_en    = 1'b0;
                nxt_ctrl.fast_xtal_en  = 1'b0;
                nxt_ctrl.pll_en        = 1'b0;
                nxt_ctrl.dom_rst       = 1'b1;                // [R11]
            end
            default:
            begin
                nxt_ctrl = CTRL_RESET;
            end
        endcase
        // Backup domain never loses power
        nxt_ctrl.backup_pwr_en = 1'b1;                        // [R8]
    end

    // Registered so every enable leaves the block glitch-free
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            ctrl_ff <= CTRL_RESET;
        else
            ctrl_ff <= nxt_ctrl;
    end

    // ------------------------------------------------------------------
    // Clock select and supply warning
    // ------------------------------------------------------------------
    // One-cycle pulse that forces the RC as system clock on wake
    always_comb
    begin
        nxt_rc_sel   = ((state_ff == LPM_ST_DEEP_WAKE)
                     || (state_ff == LPM_ST_STBY_WAKE))
                     && (nxt_state == LPM_ST_RUN);            // [R6]
        nxt_drop_irq = drop_rise;                             // [R10]
    end

    // Pulses last one cycle; a level held high pulses only once
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            rc_sel_ff   <= 1'b0;
            drop_irq_ff <= 1'b0;
        end
        else
        begin
            rc_sel_ff   <= nxt_rc_sel;
            drop_irq_ff <= nxt_drop_irq;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ctrl_out            = ctrl_ff;
    assign state_out           = state_ff;
    assign rc_sel_out          = rc_sel_ff;
    assign supply_drop_irq_out = drop_irq_ff;

endmodule

`default_nettype wire

// [logic/lpm_pkg.sv]
`default_nettype none

package lpm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    // Fast RC start-up before core-domain clocks come back (least time)
    localparam int unsigned RC_SETTLE_NS  = 2000;
    localparam int unsigned RC_SETTLE_CYC =
        (RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Core-domain reset held after power returns (least time)
    localparam int unsigned RST_HOLD_NS   = 1000;
    localparam int unsigned RST_HOLD_CYC  =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W_DEF     = 8;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned EXT_LINES     = 16;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LPM_MODE_SLEEP = 2'h0,
        LPM_MODE_DEEP  = 2'h1,
        LPM_MODE_STBY  = 2'h2
    } lpm_mode_t;

    typedef enum logic [2:0] {
        LPM_ST_RUN       = 3'h0,
        LPM_ST_SLEEP     = 3'h1,
        LPM_ST_DEEP      = 3'h2,
        LPM_ST_DEEP_WAKE = 3'h3,
        LPM_ST_STBY      = 3'h4,
        LPM_ST_STBY_WAKE = 3'h5
    } lpm_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [EXT_LINES-1:0] ext_lines;
        logic                 rtc_alarm;
        logic                 usb_wake;
        logic                 ethernet_unit_wake;
    } lpm_wake_t;

    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic dom_clk_en;
        logic fast_rc_en;
        logic fast_xtal_en;
        logic pll_en;
        logic regulator_en;
        logic dom_pwr_en;
        logic dom_rst;
        logic backup_pwr_en;
    } lpm_ctrl_t;

    // Run-mode values, also taken at reset
    localparam lpm_ctrl_t CTRL_RESET = '{
        core_clk_en:   1'b1,
        periph_clk_en: 1'b1,
        dom_clk_en:    1'b1,
        fast_rc_en:    1'b1,
        fast_xtal_en:  1'b0,
        pll_en:        1'b0,
        regulator_en:  1'b1,
        dom_pwr_en:    1'b1,
        dom_rst:       1'b0,
        backup_pwr_en: 1'b1
    };

endpackage

`default_nettype wire

// [logic/lpm_rise_det.sv]
`timescale 1ns/1ns
`default_nettype none

module lpm_rise_det
    import lpm_pkg::*;
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         clock_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] level_in,
    output logic      [W-1:0] rise_out
);

    // ------------------------------------------------------------------
    // Rising edge finder
    // ------------------------------------------------------------------
    logic [W-1:0] last_ff;
    logic [W-1:0] nxt_last;

    // Previous level; starts high so a level already set at reset is no edge
    always_comb
    begin
        nxt_last = level_in;
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            last_ff <= '1;
        else
            last_ff <= nxt_last;
    end

    assign rise_out = level_in & ~last_ff;

endmodule

`default_nettype wire

// [verif/lpm_ctrl_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module lpm_ctrl_checker
    import lpm_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       srst_in,
    input wire logic       enter_req_in,
    input wire lpm_mode_t  mode_sel_in,
    input wire logic       irq_pending_in,
    input wire lpm_wake_t  wake_in,
    input wire logic       xtal_req_in,
    input wire logic       pll_req_in,
    input wire logic       supply_drop_in,
    input wire logic       wakeup_pin_in,
    input wire logic       ext_reset_pin_n_in,
    input wire logic       wdg_reset_in,
    input wire lpm_ctrl_t  ctrl_out,
    input wire lpm_state_t state_out,
    input wire logic       rc_sel_out,
    input wire logic       supply_drop_irq_out
);
    // ----------------------------------------
    // Mode checks, all in the one clock domain
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    // Level sources of a standby wake; the pin edge is taken in the properties
    logic stby_src;
    assign stby_src = !ext_reset_pin_n_in || wake_in.rtc_alarm || wdg_reset_in;

    sleep_clk_a: assert property (state_out == LPM_ST_SLEEP |->
        !ctrl_out.core_clk_en && ctrl_out.periph_clk_en && ctrl_out.dom_clk_en)
        else $error("sleep stops more than the core clock");
    sleep_wake_a: assert property (state_out == LPM_ST_SLEEP && irq_pending_in
        |=> state_out == LPM_ST_RUN) else $error("sleep not left on interrupt");
    deep_off_a: assert property (state_out == LPM_ST_DEEP |-> !ctrl_out.dom_clk_en
        && !ctrl_out.fast_rc_en && !ctrl_out.fast_xtal_en && !ctrl_out.pll_en
        && ctrl_out.dom_pwr_en) else $error("deep-sleep clock or power wrong");
    deep_wake_a: assert property (state_out == LPM_ST_DEEP && (|wake_in)
        |=> state_out == LPM_ST_DEEP_WAKE ##0 ctrl_out.fast_rc_en)
        else $error("deep-sleep not left on event");
    rc_sel_a: assert property (rc_sel_out == (state_out == LPM_ST_RUN &&
        ($past(state_out) == LPM_ST_DEEP_WAKE || $past(state_out) == LPM_ST_STBY_WAKE)))
        else $error("fast rc select pulse misplaced");
    stby_off_a: assert property (state_out == LPM_ST_STBY |-> !ctrl_out.dom_pwr_en
        && !ctrl_out.regulator_en && !ctrl_out.fast_rc_en && !ctrl_out.fast_xtal_en
        && !ctrl_out.pll_en && ctrl_out.backup_pwr_en && ctrl_out.dom_rst)
        else $error("standby power wrong");
    stby_hold_a: assert property (state_out == LPM_ST_STBY && !stby_src
        && !$rose(wakeup_pin_in) |=> state_out == LPM_ST_STBY)
        else $error("standby left without a source");
    stby_wake_a: assert property (state_out == LPM_ST_STBY && (stby_src
        || $rose(wakeup_pin_in)) |=> state_out == LPM_ST_STBY_WAKE)
        else $error("standby not left on a source");
    irq_pulse_a: assert property ($rose(supply_drop_in) |=>
        supply_drop_irq_out ##1 !supply_drop_irq_out) else $error("supply warning pulse wrong");
    stby_rst_a: assert property (state_out == LPM_ST_STBY_WAKE |-> ctrl_out.dom_rst
        && ctrl_out.dom_pwr_en && ctrl_out.regulator_en) else $error("standby wake without reset");

    // Main scenarios reached
    sleep_c: cover property (state_out == LPM_ST_SLEEP ##1 state_out == LPM_ST_RUN);
    deep_c: cover property (state_out == LPM_ST_DEEP_WAKE ##1 state_out == LPM_ST_RUN);
    stby_c: cover property (state_out == LPM_ST_STBY_WAKE ##1 state_out == LPM_ST_RUN);
endmodule

bind lpm_ctrl lpm_ctrl_checker u_lpm_ctrl_checker (
    .clock_in(clock_in), .srst_in(srst_in), .enter_req_in(enter_req_in),
    .mode_sel_in(mode_sel_in), .irq_pending_in(irq_pending_in), .wake_in(wake_in),
    .xtal_req_in(xtal_req_in), .pll_req_in(pll_req_in), .supply_drop_in(supply_drop_in),
    .wakeup_pin_in(wakeup_pin_in), .ext_reset_pin_n_in(ext_reset_pin_n_in),
    .wdg_reset_in(wdg_reset_in), .ctrl_out(ctrl_out), .state_out(state_out),
    .rc_sel_out(rc_sel_out), .supply_drop_irq_out(supply_drop_irq_out)
);

`default_nettype wire

// [verif/lpm_partner.sv]
`timescale 1ns/1ns
`default_nettype none

module lpm_partner
    import lpm_pkg::*;
(
    input  wire logic      clock_in,
    output var lpm_wake_t  wake_out,
    output var logic       irq_out,
    output var logic       drop_out,
    output var logic       pin_out,
    output var logic       rst_pin_n_out,
    output var logic       wdg_out
);
    // ----------------------------------------
    // Wake sources, idle until fired
    // ----------------------------------------
    // Idle levels; the reset pin rests high
    task automatic idle();
        wake_out = '0;
        {irq_out, drop_out, pin_out, wdg_out} = 4'h0;
        rst_pin_n_out = 1'b1;
    endtask

    initial idle();

    // One source for one cycle, called at a falling edge
    task automatic fire(input int code);
        case (code)
            0: wake_out.ext_lines[0] = 1'b1;
            1: wake_out.ext_lines[15] = 1'b1;
            2: wake_out.rtc_alarm = 1'b1;
            3: wake_out.usb_wake = 1'b1;
            4: wake_out.ethernet_unit_wake = 1'b1;
            5: drop_out = 1'b1;
            6: rst_pin_n_out = 1'b0;
            7: wdg_out = 1'b1;
            8: pin_out = 1'b1;
            default: irq_out = 1'b1;
        endcase
        @(negedge clock_in);
        idle();
    endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import lpm_pkg::*;

    // Short counts keep the run brief
    localparam int RC_T   = 4;
    localparam int HOLD_T = 3;

    logic       clock_in = 1'b0;
    logic       srst_in;
    logic       enter_req;
    lpm_mode_t  mode_sel;
    logic       xtal_req;
    logic       pll_req;
    lpm_wake_t  wake;
    logic       irq_pending;
    logic       drop;
    logic       pin;
    logic       rst_pin_n;
    logic       wdg;
    lpm_ctrl_t  ctrl;
    lpm_state_t state;
    logic       rc_sel;
    logic       drop_irq;
    int         n_mismatch = 0;
    int         checked = 0;

    lpm_ctrl #(.RC_SETTLE(RC_T), .RST_HOLD(HOLD_T)) u_lpm_ctrl (
        .clock_in(clock_in), .srst_in(srst_in), .enter_req_in(enter_req),
        .mode_sel_in(mode_sel), .irq_pending_in(irq_pending), .wake_in(wake),
        .xtal_req_in(xtal_req), .pll_req_in(pll_req), .supply_drop_in(drop),
        .wakeup_pin_in(pin), .ext_reset_pin_n_in(rst_pin_n), .wdg_reset_in(wdg),
        .ctrl_out(ctrl), .state_out(state), .rc_sel_out(rc_sel),
        .supply_drop_irq_out(drop_irq));
    lpm_partner u_lpm_partner (
        .clock_in(clock_in), .wake_out(wake), .irq_out(irq_pending), .drop_out(drop),
        .pin_out(pin), .rst_pin_n_out(rst_pin_n), .wdg_out(wdg));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Request held over one rising edge, then dropped
    task automatic enter(input lpm_mode_t m);
        @(negedge clock_in);
        enter_req = 1'b1;
        mode_sel = m;
        @(negedge clock_in);
        enter_req = 1'b0;
    endtask

    // Bounded count of cycles until the run state shows
    task automatic wait_run(output int n);
        n = 0;
        while (state !== LPM_ST_RUN && n < 200)
        begin
            @(negedge clock_in);
            n++;
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sleep();
        for (int k = 0; k < 2; k++)
        begin
            enter(LPM_MODE_SLEEP);
            check("sleep core clock", ctrl.core_clk_en, 8'h00);
            check("sleep periph clock", ctrl.periph_clk_en, 8'h01);
            u_lpm_partner.fire(k == 0 ? 9 : 3);
            check("sleep wake", state, LPM_ST_RUN);
        end
        $display("t_sleep done");
    endtask

    task automatic t_deep();
        int n;
        for (int c = 0; c < 6; c++)
        begin
            enter(LPM_MODE_DEEP);
            check("deep clocks", {ctrl.core_clk_en, ctrl.periph_clk_en, ctrl.dom_clk_en,
                ctrl.fast_rc_en, ctrl.fast_xtal_en, ctrl.pll_en}, 8'h00);
            check("deep power", ctrl.dom_pwr_en, 8'h01);
            u_lpm_partner.fire(8);
            check("deep ignores pin", state, LPM_ST_DEEP);
            u_lpm_partner.fire(c);
            check("deep wake", state, LPM_ST_DEEP_WAKE);
            check("deep wake rc", ctrl.fast_rc_en, 8'h01);
            wait_run(n);
            check("rc settle", 8'(n), 8'(RC_T));
            check("rc select", rc_sel, 8'h01);
            @(negedge clock_in);
            check("rc select end", rc_sel, 8'h00);
        end
        $display("t_deep done");
    endtask

    task automatic t_stby();
        int n;
        int src[4] = '{6, 7, 8, 2};
        for (int i = 0; i < 4; i++)
        begin
            enter(LPM_MODE_STBY);
            check("stby supplies", {ctrl.regulator_en, ctrl.dom_pwr_en, ctrl.fast_rc_en,
                ctrl.fast_xtal_en, ctrl.pll_en}, 8'h00);
            check("stby backup", ctrl.backup_pwr_en, 8'h01);
            check("stby core reset", ctrl.dom_rst, 8'h01);
            u_lpm_partner.fire(3);
            check("stby ignores usb", state, LPM_ST_STBY);
            u_lpm_partner.fire(src[i]);
            check("stby wake", state, LPM_ST_STBY_WAKE);
            check("core reset on", ctrl.dom_rst, 8'h01);
            wait_run(n);
            check("reset hold", 8'(n), 8'(HOLD_T));
            check("core reset off", ctrl.dom_rst, 8'h00);
        end
        $display("t_stby done");
    endtask

    task automatic t_drop();
        u_lpm_partner.fire(5);
        check("drop warning", drop_irq, 8'h01);
        @(negedge clock_in);
        check("drop warning end", drop_irq, 8'h00);
        enter(lpm_mode_t'(2'h3));
        check("unused mode", state, LPM_ST_RUN);
        $display("t_drop done");
    endtask

    // Free-running 50 MHz clock
    initial
    begin
        forever #10 clock_in = ~clock_in;
    end

    // Main sequence; crystal and PLL asked for throughout
    initial
    begin
        srst_in = 1'b1;
        enter_req = 1'b0;
        mode_sel = LPM_MODE_SLEEP;
        xtal_req = 1'b1;
        pll_req = 1'b1;
        repeat (20) @(negedge clock_in);
        srst_in = 1'b0;
        t_sleep();
        t_deep();
        t_stby();
        t_drop();
        end_of_test();
    end

    // Hang guard, well beyond the roughly 110 cycles needed
    initial
    begin
        repeat (3000) @(posedge clock_in);
        n_mismatch++;
        end_of_test();
    end
endmodule

`default_nettype wire
